// file: hw/sfpi_pkg.sv
// Shared constants and types of the serial flash pin interface.
// Assumes one system clock that samples every pin of the link.
package sfpi_pkg;
	localparam int BYTE_W = 8;
	localparam int FIFO_DEPTH = 16;
	localparam logic [3:0] CNT_RST = 4'h0;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [3:0] LANES_OFF = 4'h0;

	typedef enum logic [1:0] {LM_SINGLE, LM_DUAL, LM_QUAD} sfpi_lane_e;

	// Sampled link pins: clock, select and the four data lanes
	typedef struct packed {
		logic sck;
		logic csN;
		logic [3:0] lane;
	} sfpi_pins_s;

	// Lane drive toward the pins, enable high while driving
	typedef struct packed {
		logic [3:0] out;
		logic [3:0] oe;
	} sfpi_drive_s;

	typedef struct packed {
		sfpi_pins_s sync1;
		sfpi_pins_s sync2;
		logic sckPrev;
		logic csPrev;
		logic armed;
		logic [7:0] rxSh;
		logic [3:0] rxCnt;
		logic [7:0] txSh;
		logic [3:0] txCnt;
		sfpi_drive_s drive;
		logic pushValid;
		logic [7:0] pushData;
		logic txTaken;
		logic overflow;
		logic standby;
		logic progGrant;
	} sfpi_state_s;
endpackage

// file: hw/sfpi_fifo.sv
// Flop-based FIFO with valid/ready on both sides.
// Assumes a single clock domain and a power-of-two depth.
`timescale 1ns/1ps
module sfpi_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [WIDTH-1:0] inData,
	input wire logic inValid,
	output logic inReady,
	output logic [WIDTH-1:0] outData,
	output logic outValid,
	input wire logic outReady
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : gBadParam
		$error("sfpi_fifo: DEPTH must be a power of two of at least 2");
	end

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
	} sfpi_fifo_s;

	sfpi_fifo_s q, d;
	logic doPush;
	logic doPop;

	assign inReady = q.cnt != (AW+1)'(DEPTH);
	assign outValid = q.cnt != '0;
	assign outData = q.mem[q.rd];
	assign doPush = inValid && inReady;
	assign doPop = outValid && outReady;

	always_comb begin
		d = q;
		if (doPush) begin
			d.mem[q.wr] = inData;
			d.wr = q.wr + 1'b1;
		end
		if (doPop) begin
			d.rd = q.rd + 1'b1;
		end
		if (doPush && !doPop) begin
			d.cnt = q.cnt + 1'b1;
		end else if (doPop && !doPush) begin
			d.cnt = q.cnt - 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule

// file: hw/sfpi_core.sv
// Device-side pin logic of a serial flash: lane sampling, shifting, float control.
// Assumes all pins are asynchronous to clk_sys and the link clock is far slower.
// Functional notes
// - Output bits change only after a falling edge of the serial clock.
// - The output lane one is also a data lane in dual and quad transfers.
// - Input lanes are sampled on rising serial clock edges; host sets them up before.
// - The input lane zero becomes a driven data lane in dual and quad transfers.
// - Select low means active; select high floats every output lane.
// - Nothing is accepted until the first select falling edge after reset.
// - Standby only while deselected and no internal write operation runs.
// - Pause low suspends transfer: outputs float, clock and inputs ignored.
// - In quad mode pause and write protect pins are lanes three and two.
// - Write protect low blocks program or erase of the protected region.
// - The quad enable bit reassigns write protect and pause pins to lanes.
`timescale 1ns/1ps
module sfpi_core
	import sfpi_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire sfpi_pins_s pinsIn,
	output sfpi_drive_s laneDrive,
	input wire sfpi_lane_e laneMode,
	input wire logic dirOut,
	input wire logic quadEnable,
	input wire logic internalBusy,
	input wire logic progRequest,
	input wire logic regionProtected,
	output logic progGrant,
	output logic standby,
	input wire logic [7:0] txData,
	output logic txTaken,
	output logic [7:0] rxData,
	output logic rxValid,
	input wire logic rxReady,
	output logic overflow
);
	if (DEPTH < 2) begin : gBadDepth
		$error("sfpi_core: DEPTH below 2");
	end

	sfpi_state_s q, d;
	logic fifoReady;
	logic selected;
	logic csFall;
	logic rise;
	logic fall;
	logic pauseOn;
	logic wpActive;
	logic [3:0] nBits;
	logic [3:0] rxSum;
	logic [3:0] txSum;
	logic [7:0] rxNext;
	logic [7:0] txByte;

	// Bits moved per edge; quad needs the enable bit, otherwise single
	function automatic logic [3:0] laneWidth(input sfpi_lane_e m, input logic qe);
		logic [3:0] w;
		w = 4'h1;
		if (m == LM_DUAL) begin
			w = 4'h2;
		end else if (m == LM_QUAD && qe) begin
			w = 4'h4;
		end
		return w;
	endfunction

	// Lanes driven for a given width
	function automatic logic [3:0] laneMask(input logic [3:0] w);
		logic [3:0] m;
		m = 4'h2;
		if (w == 4'h2) begin
			m = 4'h3;
		end else if (w == 4'h4) begin
			m = 4'hf;
		end
		return m;
	endfunction

	always_comb begin
		selected = !q.sync2.csN;
		csFall = q.csPrev && !q.sync2.csN;
		// Edges found on the sampled level, so either idle level works
		rise = !q.sckPrev && q.sync2.sck;
		fall = q.sckPrev && !q.sync2.sck;
		pauseOn = selected && !quadEnable && !q.sync2.lane[3];
		wpActive = !quadEnable && !q.sync2.lane[2];
		nBits = laneWidth(laneMode, quadEnable);
		rxSum = q.rxCnt + nBits;
		txSum = q.txCnt + nBits;
		rxNext = {q.rxSh[6:0], q.sync2.lane[0]};
		if (nBits == 4'h2) begin
			rxNext = {q.rxSh[5:0], q.sync2.lane[1:0]};
		end else if (nBits == 4'h4) begin
			rxNext = {q.rxSh[3:0], q.sync2.lane[3:0]};
		end
		txByte = (q.txCnt == CNT_RST) ? txData : q.txSh;
	end

	always_comb begin
		d = q;
		d.sync1 = pinsIn;
		d.sync2 = q.sync1;
		d.sckPrev = q.sync2.sck;
		d.csPrev = q.sync2.csN;
		d.pushValid = 1'b0;
		d.txTaken = 1'b0;
		d.standby = !selected && !internalBusy;
		d.progGrant = progRequest && !(wpActive && regionProtected);
		if (q.pushValid && !fifoReady) begin
			d.overflow = 1'b1;
		end
		if (csFall) begin
			d.armed = 1'b1;
			d.rxCnt = CNT_RST;
			d.txCnt = CNT_RST;
		end
		if (!selected) begin
			d.drive.oe = LANES_OFF;
			d.rxCnt = CNT_RST;
			d.txCnt = CNT_RST;
		end else if (q.armed && !pauseOn) begin
			if (rise) begin
				d.rxSh = rxNext;
				if (rxSum >= BYTE_BITS) begin
					d.rxCnt = CNT_RST;
					d.pushValid = 1'b1;
					d.pushData = rxNext;
				end else begin
					d.rxCnt = rxSum;
				end
			end
			if (!dirOut) begin
				d.drive.oe = LANES_OFF;
			end else if (fall) begin
				d.txTaken = q.txCnt == CNT_RST;
				d.drive.out = LANES_OFF;
				if (nBits == 4'h1) begin
					d.drive.out[1] = txByte[7];
				end else if (nBits == 4'h2) begin
					d.drive.out[1:0] = txByte[7:6];
				end else begin
					d.drive.out = txByte[7:4];
				end
				d.drive.oe = laneMask(nBits);
				d.txSh = txByte << nBits;
				d.txCnt = (txSum >= BYTE_BITS) ? CNT_RST : txSum;
			end
		end else begin
			// Paused or not yet armed: float, hold the bit position
			d.drive.oe = LANES_OFF;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			// Select chain resets low: a select held low through reset is no edge
			// Costs two cycles of a selected look after reset, harmless while unarmed
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Host side stalls cannot stop the link; a full FIFO sets overflow
	sfpi_fifo #(
		.WIDTH(BYTE_W),
		.DEPTH(DEPTH)
	) uFifo (
		.clk_sys(clk_sys),
		.rst(rst),
		.inData(q.pushData),
		.inValid(q.pushValid),
		.inReady(fifoReady),
		.outData(rxData),
		.outValid(rxValid),
		.outReady(rxReady)
	);

	assign laneDrive = q.drive;
	assign progGrant = q.progGrant;
	assign standby = q.standby;
	assign txTaken = q.txTaken;
	assign overflow = q.overflow;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence csFallSeq;
		q.csPrev && !q.sync2.csN;
	endsequence

	sequence pausedSeq;
		pauseOn && !csFall;
	endsequence

	deselect_float_a: assert property (q.sync2.csN |=> laneDrive.oe == LANES_OFF)
		else $error("lanes driven while deselected");
	first_fall_a: assert property (csFallSeq |=> q.armed)
		else $error("select falling edge did not arm");
	unarmed_quiet_a: assert property (!q.armed && !csFall |=> !q.pushValid && laneDrive.oe == LANES_OFF)
		else $error("activity before first select edge");
	pause_float_a: assert property (pausedSeq |=> laneDrive.oe == LANES_OFF && $stable(q.rxCnt))
		else $error("pause did not suspend transfer");
	standby_entry_a: assert property (q.sync2.csN && !internalBusy |=> standby)
		else $error("standby not entered");
	standby_busy_a: assert property (internalBusy |=> !standby)
		else $error("standby during internal write");
	rise_sample_a: assert property (q.pushValid |-> $past(rise) && $past(q.armed))
		else $error("byte completed without rising edge");
	fall_shift_a: assert property ($changed(laneDrive.out) |-> $past(fall) && $past(dirOut))
		else $error("output changed off a falling edge");
	quad_lanes_a: assert property (laneDrive.oe[3:2] != 2'h0 |-> $past(quadEnable))
		else $error("upper lanes driven without quad enable");
	lane_zero_a: assert property (laneDrive.oe[0] |-> $past(laneMode) != LM_SINGLE)
		else $error("lane zero driven in single mode");
	wp_block_a: assert property (progRequest && wpActive && regionProtected |=> !progGrant)
		else $error("protected region write granted");
	grant_open_a: assert property (progRequest && !regionProtected |=> progGrant)
		else $error("unprotected write not granted");
	take_on_fall_a: assert property (txTaken |-> $past(fall) && $past(q.txCnt) == CNT_RST)
		else $error("byte taken off a falling edge");
	dual_lanes_a: assert property (laneDrive.oe == 4'h3 |-> $past(laneMode) == LM_DUAL)
		else $error("two lanes driven outside dual mode");
endmodule

// file: verif/sfpi_host_model.sv
// Host bus master model: drives clock, select and its share of the lanes.
// Assumes the bench resolves each lane from both parties' enables.
`timescale 1ns/1ps
module sfpi_host_model (
	output logic sck,
	output logic csN,
	output logic [3:0] hostOut,
	output logic [3:0] hostOe,
	input wire logic [3:0] laneSeen
);
	initial begin
		sck = 1'b0;
		csN = 1'b1;
		hostOut = 4'hc;
		hostOe = 4'hd;
	end
	// All four lanes read late in the high phase, so a slow sync chain still makes it
	task automatic cycle(input logic [3:0] oe, input logic [3:0] v, output logic [3:0] got);
		hostOe = oe;
		hostOut = v;
		#80 sck = 1'b1;
		#80 got = laneSeen;
		sck = 1'b0;
	endtask
	task automatic select(input logic sel);
		#40 csN = !sel;
		#100;
	endtask
endmodule

// file: verif/testbench.sv
// Self-checking bench of the pin logic with a host model on the lanes.
// Assumes the core header as declared; bodies unseen.
`timescale 1ns/1ps
module testbench
	import sfpi_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	sfpi_lane_e laneMode;
	logic dirOut;
	logic quadEnable;
	logic internalBusy;
	logic progRequest;
	logic regionProtected;
	logic [7:0] txData;
	logic rxReady;
	logic [3:0] floatPat = 4'h5;
	logic sck, csN, progGrant, standby, txTaken, rxValid, overflow;
	logic [3:0] hostOut, hostOe, lanes, g;
	logic [7:0] rxData, r;
	sfpi_drive_s laneDrive;
	sfpi_pins_s pins;
	int failCount = 0;
	int checked = 0;
	int takenCount = 0;
	always #10 clk_sys = ~clk_sys;
	// Released lanes toggle so a stale value cannot pass
	always @(posedge clk_sys) floatPat <= ~floatPat;
	// One pulse per byte started; counted so a missed or doubled pulse shows
	always @(posedge clk_sys) begin
		if (txTaken === 1'b1) begin
			takenCount <= takenCount + 1;
		end
	end
	assign lanes = (laneDrive.oe & laneDrive.out) | (~laneDrive.oe & hostOe & hostOut)
		| (~laneDrive.oe & ~hostOe & floatPat);
	assign pins = {sck, csN, lanes};
	sfpi_host_model sfpi_host_model_i (.sck(sck), .csN(csN), .hostOut(hostOut), .hostOe(hostOe),
		.laneSeen(lanes));
	sfpi_core sfpi_core_i (.clk_sys(clk_sys), .rst(rst), .pinsIn(pins), .laneDrive(laneDrive),
		.laneMode(laneMode), .dirOut(dirOut), .quadEnable(quadEnable), .internalBusy(internalBusy),
		.progRequest(progRequest), .regionProtected(regionProtected), .progGrant(progGrant),
		.standby(standby), .txData(txData), .txTaken(txTaken), .rxData(rxData), .rxValid(rxValid),
		.rxReady(rxReady), .overflow(overflow));
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", checked, failCount);
		if (failCount == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failCount++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic clks(input int n);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask
	task automatic xfer(input logic [7:0] tx);
		for (int i = 7; i >= 0; i--) begin
			sfpi_host_model_i.cycle(4'hd, {3'b110, tx[i]}, g);
			r = {r[6:0], g[1]};
		end
		#80 r = {r[6:0], lanes[1]};
	endtask
	task automatic wait_rx(input logic [7:0] exp);
		int n;
		n = 0;
		clks(1);
		while (rxValid !== 1'b1 && n < 100) begin
			clks(1);
			n++;
		end
		if (n == 100) begin
			failCount++;
			end_sim();
		end else begin
			check(rxData, exp);
			rxReady = 1'b1;
			clks(1);
			rxReady = 1'b0;
		end
	endtask
	task automatic t_arm();
		dirOut = 1'b1;
		xfer(8'hff);
		clks(20);
		check(rxValid, 1'b0);
		check(laneDrive.oe, 4'h0);
		sfpi_host_model_i.select(1'b0);
	endtask
	task automatic t_single();
		int n0;
		txData = 8'h3c;
		sfpi_host_model_i.select(1'b1);
		n0 = takenCount;
		xfer(8'ha5);
		check(laneDrive.oe, 4'h2);
		check(r, 8'h3c);
		check(takenCount - n0, 1);
		wait_rx(8'ha5);
		sfpi_host_model_i.select(1'b0);
		clks(5);
		check(laneDrive.oe, 4'h0);
		check(standby, 1'b1);
		internalBusy = 1'b1;
		clks(3);
		check(standby, 1'b0);
		internalBusy = 1'b0;
	endtask
	task automatic t_pause();
		sfpi_host_model_i.select(1'b1);
		// Pause only while selected
		for (int i = 0; i < 8; i++) sfpi_host_model_i.cycle(4'hd, 4'h5, g);
		check(laneDrive.oe, 4'h0);
		check(rxValid, 1'b0);
		xfer(8'h81);
		wait_rx(8'h81);
		sfpi_host_model_i.select(1'b0);
	endtask
	task automatic t_protect();
		sfpi_host_model_i.cycle(4'hd, 4'h9, g);
		progRequest = 1'b1;
		regionProtected = 1'b1;
		clks(5);
		check(progGrant, 1'b0);
		regionProtected = 1'b0;
		clks(3);
		check(progGrant, 1'b1);
		regionProtected = 1'b1;
		quadEnable = 1'b1;
		clks(3);
		check(progGrant, 1'b1);
	endtask
	// Host releases lanes 0 and 1; two bits per falling edge, MSB pair first
	task automatic t_dual();
		int n0;
		laneMode = LM_DUAL;
		dirOut = 1'b1;
		txData = 8'hc6;
		sfpi_host_model_i.select(1'b1);
		n0 = takenCount;
		sfpi_host_model_i.cycle(4'hc, 4'hc, g);
		for (int i = 0; i < 3; i++) begin
			sfpi_host_model_i.cycle(4'hc, 4'hc, g);
			r = {r[5:0], g[1:0]};
		end
		#80 r = {r[5:0], lanes[1:0]};
		check(r, 8'hc6);
		check(laneDrive.oe, 4'h3);
		check(takenCount - n0, 1);
		sfpi_host_model_i.select(1'b0);
	endtask
	// Host releases all lanes; the device drives a nibble per falling edge
	task automatic t_quad_read();
		int n0;
		laneMode = LM_QUAD;
		txData = 8'h96;
		sfpi_host_model_i.select(1'b1);
		n0 = takenCount;
		sfpi_host_model_i.cycle(4'h0, 4'h0, g);
		sfpi_host_model_i.cycle(4'h0, 4'h0, g);
		r = {r[3:0], g};
		#80 r = {r[3:0], lanes};
		check(r, 8'h96);
		check(laneDrive.oe, 4'hf);
		check(takenCount - n0, 1);
		sfpi_host_model_i.select(1'b0);
		clks(5);
		check(laneDrive.oe, 4'h0);
	endtask
	task automatic t_quad_fifo();
		laneMode = LM_QUAD;
		dirOut = 1'b0;
		sfpi_host_model_i.select(1'b1);
		for (int i = 0; i < 17; i++) begin
			r = 8'h10 + i[7:0];
			sfpi_host_model_i.cycle(4'hf, r[7:4], g);
			sfpi_host_model_i.cycle(4'hf, r[3:0], g);
		end
		clks(8);
		check(overflow, 1'b1);
		sfpi_host_model_i.select(1'b0);
		for (int i = 0; i < 16; i++) wait_rx(8'h10 + i[7:0]);
		clks(2);
		check(rxValid, 1'b0);
	endtask
	initial begin
		laneMode = LM_SINGLE;
		dirOut = 1'b0;
		quadEnable = 1'b0;
		internalBusy = 1'b0;
		progRequest = 1'b0;
		regionProtected = 1'b0;
		txData = 8'h00;
		rxReady = 1'b0;
		// Select already low through reset must not arm the device
		fork
			sfpi_host_model_i.select(1'b1);
			repeat (8) @(posedge clk_sys);
		join
		#2 rst = 1'b0;
		clks(4);
		t_arm();
		t_single();
		t_pause();
		t_protect();
		t_quad_fifo();
		t_dual();
		t_quad_read();
		end_sim();
	end
endmodule
